/* File: src/tsw_regs.svh */
`ifndef TSW_REGS_SVH
`define TSW_REGS_SVH
// ============================================================
// widths
`define TSW_TIMER_W 32
`define TSW_PRESC_W 16
// ============================================================
// watchdog lock key, value is arbitrary
`define TSW_WD_KEY 32'h5AC3_E17B
// ============================================================
// timing
`define TSW_CLK_MHZ 200
`define TSW_RST_PULSE_NS 100
`define TSW_RST_PULSE_CYC ((`TSW_RST_PULSE_NS * `TSW_CLK_MHZ + 999) / 1000)
`define TSW_RST_CNT_W 8
`endif

/* File: src/tsw_pkg.sv */
package tsw_pkg;
   // ============================================================
   // tick source select
   typedef enum logic [0:0] {
      TSW_SRC_FAST = 1'b0,
      TSW_SRC_SLOW = 1'b1
   } tsw_src_t;
   // ============================================================
   // watchdog states
   typedef enum logic [1:0] {
      TSW_WD_OFF = 2'b00,
      TSW_WD_RUN = 2'b01,
      TSW_WD_FIRE = 2'b10
   } tsw_wd_state_t;
endpackage : tsw_pkg

/* File: src/tsw_down_counter.sv */
`timescale 1ns/10ps
`include "tsw_regs.svh"
module tsw_down_counter import tsw_pkg::*; #(
   parameter int W = `TSW_TIMER_W,
   parameter int PW = `TSW_PRESC_W
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // tick sources
   input wire logic fast_edge_in,
   input wire logic slow_edge_in,
   input wire tsw_src_t src_sel_in,
   input wire logic [PW-1:0] prescale_in,
   // control
   input wire logic load_in,
   input wire logic [W-1:0] load_val_in,
   input wire logic run_in,
   input wire logic reload_in,
   input wire logic clear_in,
   // status
   output logic [W-1:0] count_out,
   output logic flag_out,
   output logic expire_out
);
   // ============================================================
   // prescaler
   logic [PW-1:0] pre_q;
   logic [W-1:0] period_q;
   logic src_edge;
   logic tick;
   logic hit_zero;

   function automatic logic pick_edge(input tsw_src_t sel, input logic f, input logic s);
      pick_edge = (sel == TSW_SRC_SLOW) ? s : f;
   endfunction : pick_edge

   assign src_edge = pick_edge(src_sel_in, fast_edge_in, slow_edge_in);
   assign tick = src_edge && (pre_q == prescale_in);
   assign hit_zero = tick && run_in && (count_out == {{(W-1){1'b0}}, 1'b1});

   always_ff @(posedge clock_in) begin
      if (!rst_n_in || load_in) begin
         pre_q <= '0;
      end else if (src_edge) begin
         pre_q <= (pre_q == prescale_in) ? '0 : pre_q + 1'b1;
      end
   end

   // ============================================================
   // counter
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         count_out <= '0;
         period_q <= '0;
      end else if (load_in) begin
         count_out <= load_val_in;
         period_q <= load_val_in;
      end else if (hit_zero && reload_in) begin
         count_out <= period_q;
      end else if (tick && run_in && count_out != '0) begin
         count_out <= count_out - 1'b1;
      end
   end

   // ============================================================
   // expiry pulse and sticky flag, set wins over clear
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         expire_out <= 1'b0;
         flag_out <= 1'b0;
      end else begin
         expire_out <= hit_zero && !load_in;
         if (hit_zero && !load_in) begin
            flag_out <= 1'b1;
         end else if (clear_in) begin
            flag_out <= 1'b0;
         end
      end
   end
endmodule : tsw_down_counter

/* File: src/tsw_top.sv */
`timescale 1ns/10ps
`include "tsw_regs.svh"
// Overview of operation
// - two independent 32-bit general countdown timers counting downward
// - reaching zero sets that timer's status flag and interrupt request
// - tick period comes from selectable clock source and prescale ratio
// - 32-bit wakeup timer expiry can wake the system from low power
// - wakeup timer also serves as a plain event timer
// - system guard timer timeout requests a system reset
// - guard timer is off after reset; runs only once software enables it
// - guard control writes blocked until the lock key is written
// - tick source is the 24 MHz or the 120 kHz internal oscillator
// - guard counter pauses while debugger halts the processor
// - guard reset is an output pulse; afterwards the guard only returns to off, keeping its unlock and timeout registers
module tsw_top import tsw_pkg::*; #(
   parameter int W = `TSW_TIMER_W,
   parameter int PW = `TSW_PRESC_W
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // oscillator pins
   input wire logic osc_fast_in,
   input wire logic osc_slow_in,
   // general countdown timers
   input wire logic [1:0] gct_load_in,
   input wire logic [W-1:0] gct_load_val_in [2],
   input wire logic [1:0] gct_run_in,
   input wire logic [1:0] gct_reload_in,
   input wire tsw_src_t gct_src_sel_in [2],
   input wire logic [PW-1:0] gct_prescale_in [2],
   input wire logic [1:0] gct_clear_in,
   output logic [W-1:0] gct_count_out [2],
   output logic [1:0] gct_status_out,
   output logic [1:0] gct_irq_out,
   // wakeup timer
   input wire logic wkt_load_in,
   input wire logic [W-1:0] wkt_load_val_in,
   input wire logic wkt_run_in,
   input wire logic wkt_reload_in,
   input wire logic wkt_wake_mode_in,
   input wire tsw_src_t wkt_src_sel_in,
   input wire logic [PW-1:0] wkt_prescale_in,
   input wire logic wkt_clear_in,
   input wire logic sleep_in,
   output logic [W-1:0] wkt_count_out,
   output logic wkt_status_out,
   output logic wkt_irq_out,
   output logic wkt_wake_out,
   // system guard timer
   input wire logic sgt_lock_wr_in,
   input wire logic [W-1:0] sgt_lock_data_in,
   input wire logic sgt_ctrl_wr_in,
   input wire logic sgt_ctrl_enable_in,
   input wire logic [W-1:0] sgt_ctrl_timeout_in,
   input wire tsw_src_t sgt_src_sel_in,
   input wire logic [PW-1:0] sgt_prescale_in,
   input wire logic sgt_kick_in,
   input wire logic debug_halt_in,
   output logic [W-1:0] sgt_count_out,
   output logic sgt_unlocked_out,
   output logic sgt_enabled_out,
   output logic sys_reset_out
);
   // ============================================================
   // oscillator synchronisers and edge detect
   logic fast_s1_q, fast_s2_q, fast_s3_q;
   logic slow_s1_q, slow_s2_q, slow_s3_q;
   logic fast_edge, slow_edge;

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         fast_s1_q <= 1'b0;
         fast_s2_q <= 1'b0;
         fast_s3_q <= 1'b0;
         slow_s1_q <= 1'b0;
         slow_s2_q <= 1'b0;
         slow_s3_q <= 1'b0;
      end else begin
         fast_s1_q <= osc_fast_in;
         fast_s2_q <= fast_s1_q;
         fast_s3_q <= fast_s2_q;
         slow_s1_q <= osc_slow_in;
         slow_s2_q <= slow_s1_q;
         slow_s3_q <= slow_s2_q;
      end
   end

   // 24 MHz sampled at 200 MHz leaves >4 samples per period
   assign fast_edge = fast_s2_q && !fast_s3_q;
   assign slow_edge = slow_s2_q && !slow_s3_q;

   // ============================================================
   // general countdown timers
   logic [1:0] gct_exp;

   for (genvar i = 0; i < 2; i++) begin : g_gct
      tsw_down_counter #(.W(W), .PW(PW)) u_gct (
         .clock_in(clock_in),
         .rst_n_in(rst_n_in),
         .fast_edge_in(fast_edge),
         .slow_edge_in(slow_edge),
         .src_sel_in(gct_src_sel_in[i]),
         .prescale_in(gct_prescale_in[i]),
         .load_in(gct_load_in[i]),
         .load_val_in(gct_load_val_in[i]),
         .run_in(gct_run_in[i]),
         .reload_in(gct_reload_in[i]),
         .clear_in(gct_clear_in[i]),
         .count_out(gct_count_out[i]),
         .flag_out(gct_status_out[i]),
         .expire_out(gct_exp[i])
      );
   end

   // irq mirrors the sticky flag, one cycle behind it
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         gct_irq_out <= 2'h0;
      end else begin
         gct_irq_out <= gct_status_out | gct_exp;
      end
   end

   // ============================================================
   // wakeup timer
   logic wkt_exp;

   tsw_down_counter #(.W(W), .PW(PW)) u_wkt (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .fast_edge_in(fast_edge),
      .slow_edge_in(slow_edge),
      .src_sel_in(wkt_src_sel_in),
      .prescale_in(wkt_prescale_in),
      .load_in(wkt_load_in),
      .load_val_in(wkt_load_val_in),
      .run_in(wkt_run_in),
      .reload_in(wkt_reload_in),
      .clear_in(wkt_clear_in),
      .count_out(wkt_count_out),
      .flag_out(wkt_status_out),
      .expire_out(wkt_exp)
   );

   // wake stays asserted until software clears the flag or sleep ends
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         wkt_irq_out <= 1'b0;
         wkt_wake_out <= 1'b0;
      end else begin
         wkt_irq_out <= wkt_status_out | wkt_exp;
         if (wkt_exp && wkt_wake_mode_in && sleep_in) begin
            wkt_wake_out <= 1'b1;
         end else if (wkt_clear_in || !sleep_in) begin
            wkt_wake_out <= 1'b0;
         end
      end
   end

   // ============================================================
   // system guard timer lock
   logic key_ok;
   logic ctrl_ok;
   tsw_wd_state_t wd_state_q;
   logic [`TSW_RST_CNT_W-1:0] rst_cnt_q;
   logic sgt_exp;
   logic sgt_load;
   logic sgt_run;
   logic [W-1:0] sgt_timeout_q;
   logic [W-1:0] sgt_load_val;

   assign key_ok = sgt_lock_wr_in && (sgt_lock_data_in == `TSW_WD_KEY);
   assign ctrl_ok = sgt_ctrl_wr_in && sgt_unlocked_out;

   // one control write per unlock, so a runaway loop needs the key again
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         sgt_unlocked_out <= 1'b0;
      end else if (key_ok) begin
         sgt_unlocked_out <= 1'b1;
      end else if (sgt_ctrl_wr_in || sgt_lock_wr_in) begin
         sgt_unlocked_out <= 1'b0;
      end
   end

   // ============================================================
   // system guard timer state
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         wd_state_q <= TSW_WD_OFF;
         rst_cnt_q <= '0;
      end else begin
         case (wd_state_q)
            TSW_WD_OFF: begin
               if (ctrl_ok && sgt_ctrl_enable_in) begin
                  wd_state_q <= TSW_WD_RUN;
               end
            end
            TSW_WD_RUN: begin
               if (sgt_exp) begin
                  wd_state_q <= TSW_WD_FIRE;
                  rst_cnt_q <= `TSW_RST_CNT_W'(`TSW_RST_PULSE_CYC);
               end else if (ctrl_ok && !sgt_ctrl_enable_in) begin
                  wd_state_q <= TSW_WD_OFF;
               end
            end
            TSW_WD_FIRE: begin
               if (rst_cnt_q == `TSW_RST_CNT_W'(1)) begin
                  wd_state_q <= TSW_WD_OFF;
               end
               rst_cnt_q <= rst_cnt_q - 1'b1;
            end
            default: begin
               wd_state_q <= TSW_WD_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         sys_reset_out <= 1'b0;
         sgt_enabled_out <= 1'b0;
      end else begin
         sys_reset_out <= (wd_state_q == TSW_WD_FIRE);
         sgt_enabled_out <= (wd_state_q == TSW_WD_RUN);
      end
   end

   // kick and enable both restart the count from the timeout value
   assign sgt_load = (ctrl_ok && sgt_ctrl_enable_in) || (sgt_kick_in && wd_state_q == TSW_WD_RUN);
   assign sgt_run = (wd_state_q == TSW_WD_RUN) && !debug_halt_in;
   // a kick reloads the timeout latched at the last accepted control write
   assign sgt_load_val = ctrl_ok ? sgt_ctrl_timeout_in : sgt_timeout_q;

   tsw_down_counter #(.W(W), .PW(PW)) u_sgt (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .fast_edge_in(fast_edge),
      .slow_edge_in(slow_edge),
      .src_sel_in(sgt_src_sel_in),
      .prescale_in(sgt_prescale_in),
      .load_in(sgt_load),
      .load_val_in(sgt_load_val),
      .run_in(sgt_run),
      .reload_in(1'b0),
      .clear_in(1'b1),
      .count_out(sgt_count_out),
      .flag_out(),
      .expire_out(sgt_exp)
   );

   // timeout latched at each accepted control write, reused by kicks
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         sgt_timeout_q <= '0;
      end else if (ctrl_ok) begin
         sgt_timeout_q <= sgt_ctrl_timeout_in;
      end
   end
endmodule : tsw_top

/* File: tb/tsw_top_assertions.sv */
`timescale 1ns/10ps
`include "tsw_regs.svh"
module tsw_top_assertions import tsw_pkg::*; #(
   parameter int W = `TSW_TIMER_W
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // countdown timers
   input wire logic [1:0] gct_load_in,
   input wire logic [1:0] gct_clear_in,
   input wire logic [W-1:0] gct_count_out [2],
   input wire logic [1:0] gct_status_out,
   input wire logic [1:0] gct_irq_out,
   // guard timer
   input wire logic sgt_lock_wr_in,
   input wire logic [W-1:0] sgt_lock_data_in,
   input wire logic sgt_ctrl_wr_in,
   input wire logic sgt_kick_in,
   input wire logic debug_halt_in,
   input wire logic [W-1:0] sgt_count_out,
   input wire logic sgt_unlocked_out,
   input wire logic sgt_enabled_out,
   input wire logic sys_reset_out
);
   // ============================================================
   // helper: length of the reset pulse so far
   logic [7:0] hi_cnt_q;
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) hi_cnt_q <= 8'h00;
      else if (sys_reset_out) hi_cnt_q <= hi_cnt_q + 8'h01;
      else hi_cnt_q <= 8'h00;
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   // ============================================================
   // properties
   property p_irq; $rose(gct_status_out[1]) |=> gct_irq_out[1]; endproperty
   a_irq : assert property (p_irq) else $error("irq lags flag");
   property p_sticky; gct_status_out[0] && !gct_clear_in[0] |=> gct_status_out[0]; endproperty
   a_sticky : assert property (p_sticky) else $error("flag dropped");
   // count of 1 may expire in the same cycle, where set wins
   property p_clr;
      gct_clear_in[1] && !gct_load_in[1] && gct_count_out[1] != 1 |=> !gct_status_out[1];
   endproperty
   a_clr : assert property (p_clr) else $error("clear ignored");
   property p_key; sgt_lock_wr_in && sgt_lock_data_in == `TSW_WD_KEY |=> sgt_unlocked_out;
   endproperty
   a_key : assert property (p_key) else $error("key not taken");
   property p_relock; sgt_ctrl_wr_in && !sgt_lock_wr_in |=> !sgt_unlocked_out; endproperty
   a_relock : assert property (p_relock) else $error("still unlocked");
   property p_en;
      $rose(sgt_enabled_out) |-> $past(sgt_ctrl_wr_in, 2) && $past(sgt_unlocked_out, 2);
   endproperty
   a_en : assert property (p_en) else $error("enable without write");
   property p_len; $fell(sys_reset_out) |-> hi_cnt_q == `TSW_RST_PULSE_CYC; endproperty
   a_len : assert property (p_len) else $error("reset pulse length");
   property p_halt;
      debug_halt_in && $past(debug_halt_in) && !sgt_kick_in && !sgt_ctrl_wr_in
         |=> $stable(sgt_count_out);
   endproperty
   a_halt : assert property (p_halt) else $error("counted in halt");
endmodule : tsw_top_assertions

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`include "tsw_regs.svh"
module tb_top import tsw_pkg::*;;
   // ============================================================
   // signals
   logic clock_in = 1'h0, rst_n_in = 1'h0, osc_fast_in = 1'h0, osc_slow_in = 1'h0;
   logic [1:0] gct_load_in = 2'h0, gct_run_in = 2'h0, gct_reload_in = 2'h0, gct_clear_in = 2'h0;
   logic [31:0] gct_load_val_in [2] = '{2{32'h0}};
   tsw_src_t gct_src_sel_in [2] = '{2{TSW_SRC_FAST}};
   logic [15:0] gct_prescale_in [2] = '{2{16'h0}};
   logic wkt_load_in = 1'h0, wkt_run_in = 1'h0, wkt_reload_in = 1'h0, wkt_clear_in = 1'h0;
   logic wkt_wake_mode_in = 1'h0, sleep_in = 1'h0, sgt_lock_wr_in = 1'h0, sgt_ctrl_wr_in = 1'h0;
   logic sgt_ctrl_enable_in = 1'h0, sgt_kick_in = 1'h0, debug_halt_in = 1'h0;
   logic [31:0] wkt_load_val_in = 32'h0, sgt_lock_data_in = 32'h0, sgt_ctrl_timeout_in = 32'h0;
   tsw_src_t wkt_src_sel_in = TSW_SRC_FAST, sgt_src_sel_in = TSW_SRC_FAST;
   logic [15:0] wkt_prescale_in = 16'h0, sgt_prescale_in = 16'h0;
   logic [31:0] gct_count_out [2];
   logic [31:0] wkt_count_out, sgt_count_out, held;
   logic [1:0] gct_status_out, gct_irq_out;
   logic wkt_status_out, wkt_irq_out, wkt_wake_out, sgt_unlocked_out, sgt_enabled_out;
   logic sys_reset_out;
   int bad_count = 0;
   int n_checks = 0;
   int k;
   tsw_top i_dut (.clock_in, .rst_n_in, .osc_fast_in, .osc_slow_in, .gct_load_in, .gct_load_val_in,
      .gct_run_in, .gct_reload_in, .gct_src_sel_in, .gct_prescale_in, .gct_clear_in, .gct_count_out,
      .gct_status_out, .gct_irq_out, .wkt_load_in, .wkt_load_val_in, .wkt_run_in, .wkt_reload_in,
      .wkt_wake_mode_in, .wkt_src_sel_in, .wkt_prescale_in, .wkt_clear_in, .sleep_in, .wkt_count_out,
      .wkt_status_out, .wkt_irq_out, .wkt_wake_out, .sgt_lock_wr_in, .sgt_lock_data_in,
      .sgt_ctrl_wr_in, .sgt_ctrl_enable_in, .sgt_ctrl_timeout_in, .sgt_src_sel_in, .sgt_prescale_in,
      .sgt_kick_in, .debug_halt_in, .sgt_count_out, .sgt_unlocked_out, .sgt_enabled_out,
      .sys_reset_out);
   always #2.5 clock_in = ~clock_in;
   always #20.83 osc_fast_in = ~osc_fast_in;
   always #4166.67 osc_slow_in = ~osc_slow_in;
   // ============================================================
   // helpers
   task automatic step(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask : step
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk
   task automatic conclude();
      if (bad_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude
   // ============================================================
   // scenarios
   task automatic t_gct(input int i, input int s, input logic [31:0] val);
      gct_src_sel_in[i] = tsw_src_t'(s);
      gct_prescale_in[i] = 16'(s);
      gct_load_val_in[i] = val;
      gct_load_in[i] = 1'h1;
      step(1);
      gct_load_in[i] = 1'h0;
      chk("gct load", gct_count_out[i], val);
      gct_run_in[i] = 1'h1;
   endtask : t_gct
   task automatic t_expire(input int i);
      t_gct(i, 0, 32'h3);
      for (k = 0; k < 300 && gct_status_out[i] !== 1'h1; k++) step(1);
      chk("gct zero", gct_count_out[i], 32'h0);
      step(1);
      chk("gct irq", gct_irq_out[i], 1'h1);
      step(5);
      chk("gct sticky", gct_status_out[i], 1'h1);
      chk("gct stays zero", gct_count_out[i], 32'h0);
      gct_clear_in[i] = 1'h1;
      step(1);
      gct_clear_in[i] = 1'h0;
      chk("gct clear", gct_status_out[i], 1'h0);
      step(1);
      chk("irq clear", gct_irq_out[i], 1'h0);
      gct_run_in[i] = 1'h0;
   endtask : t_expire
   task automatic t_reload();
      gct_reload_in[0] = 1'h1;
      t_gct(0, 0, 32'h2);
      for (k = 0; k < 300 && gct_status_out[0] !== 1'h1; k++) step(1);
      chk("gct reload", gct_count_out[0], 32'h2);
      gct_run_in[0] = 1'h0;
      gct_reload_in[0] = 1'h0;
      gct_clear_in[0] = 1'h1;
      step(1);
      gct_clear_in[0] = 1'h0;
      chk("reload clear", gct_status_out[0], 1'h0);
   endtask : t_reload
   task automatic t_src(input int s);
      int n;
      real exp_c;
      // prescale s gives s+1 source periods per decrement; slack covers sync jitter
      exp_c = s ? 3333.3 : 8.33;
      t_gct(1, s, 32'h9);
      for (k = 0; k < 9000 && gct_count_out[1] == 32'h9; k++) step(1);
      for (n = 0; n < 9000 && gct_count_out[1] == 32'h8; n++) step(1);
      chk("tick period", n > exp_c - 3 && n < exp_c + 3, 1'h1);
      gct_run_in[1] = 1'h0;
   endtask : t_src
   task automatic t_wake(input logic m);
      wkt_wake_mode_in = m;
      sleep_in = 1'h1;
      wkt_load_val_in = 32'h2;
      wkt_load_in = 1'h1;
      step(1);
      wkt_load_in = 1'h0;
      wkt_run_in = 1'h1;
      for (k = 0; k < 300 && wkt_status_out !== 1'h1; k++) step(1);
      step(2);
      chk("wake irq", wkt_irq_out, 1'h1);
      chk("wake count", wkt_count_out, 32'h0);
      chk("wake out", wkt_wake_out, m);
      sleep_in = 1'h0;
      wkt_clear_in = 1'h1;
      wkt_run_in = 1'h0;
      step(1);
      wkt_clear_in = 1'h0;
      chk("wake exit", {wkt_wake_out, wkt_status_out}, 2'h0);
   endtask : t_wake
   task automatic t_guard();
      sgt_ctrl_enable_in = 1'h1;
      sgt_ctrl_timeout_in = 32'h28;
      for (k = 0; k < 4; k++) begin
         sgt_lock_data_in = k[1] ? `TSW_WD_KEY : ~`TSW_WD_KEY;
         sgt_lock_wr_in = k[0];
         sgt_ctrl_wr_in = ~k[0];
         step(1);
         chk("lock", {sgt_unlocked_out, sgt_enabled_out}, {k == 3, 1'h0});
      end
      sgt_lock_wr_in = 1'h0;
      sgt_ctrl_wr_in = 1'h1;
      step(1);
      sgt_ctrl_wr_in = 1'h0;
      step(1);
      chk("enabled", {sgt_enabled_out, sgt_unlocked_out}, 2'h2);
      debug_halt_in = 1'h1;
      step(3);
      held = sgt_count_out;
      step(60);
      chk("halted", sgt_count_out, held);
      debug_halt_in = 1'h0;
      step(60);
      sgt_kick_in = 1'h1;
      step(1);
      sgt_kick_in = 1'h0;
      chk("kicked", sgt_count_out > 32'h26, 1'h1);
      for (k = 0; k < 2000 && sys_reset_out !== 1'h1; k++) step(1);
      for (k = 0; k < 100 && sys_reset_out === 1'h1; k++) step(1);
      chk("reset pulse", k, `TSW_RST_PULSE_CYC);
      chk("guard off", sgt_enabled_out, 1'h0);
   endtask : t_guard
   // ============================================================
   // main sequence
   initial begin
      step(5);
      rst_n_in = 1'h1;
      step(4);
      chk("after reset", {sgt_enabled_out, sys_reset_out, gct_status_out}, 4'h0);
      t_expire(0);
      t_expire(1);
      t_reload();
      t_src(0);
      t_src(1);
      t_wake(1'h0);
      t_wake(1'h1);
      t_guard();
      conclude();
   end
   initial begin
      #200000;
      chk("watchdog", 32'h0, 32'h1);
      conclude();
   end
endmodule : tb_top
bind tsw_top tsw_top_assertions #(.W(W)) i_chk (.clock_in, .rst_n_in, .gct_load_in, .gct_clear_in,
   .gct_count_out, .gct_status_out, .gct_irq_out, .sgt_lock_wr_in, .sgt_lock_data_in,
   .sgt_ctrl_wr_in, .sgt_kick_in, .debug_halt_in, .sgt_count_out, .sgt_unlocked_out,
   .sgt_enabled_out, .sys_reset_out);
